// >>> logic/axi_lite_regs.sv
// axi4-lite slave front end turning bus transfers into register strobes
`include "flash_key_defs.svh"
`default_nettype none
module axi_lite_regs #(
  parameter int AW = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  output logic               wr_stb,
  output logic [AW-1:0]      wr_addr,
  output logic [31:0]        wr_data,
  input  wire logic          wr_ok,
  output logic [AW-1:0]      rd_addr,
  input  wire logic [31:0]   rd_data,
  input  wire logic          rd_ok
);
  logic          aw_held;
  logic          w_held;
  logic [3:0]    strb_held;
  wire           wr_fire;
  wire           rd_fire;

  assign awready = ~aw_held;
  assign wready  = ~w_held;
  assign arready = ~rvalid;
  assign rd_addr = araddr;
  assign wr_fire = aw_held & w_held & ~bvalid;
  // a write without lane 0 is answered but stores nothing
  assign wr_stb  = wr_fire & strb_held[0];
  assign rd_fire = arvalid & ~rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      strb_held <= 4'h0;
      wr_addr   <= '0;
      wr_data   <= 32'h0000_0000;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
    end else begin
      if (awvalid && !aw_held) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && !w_held) begin
        w_held    <= 1'b1;
        wr_data   <= wdata;
        strb_held <= wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= rd_data;
      rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : axi_lite_regs
`default_nettype wire

// >>> logic/download_engine.sv
// word copier that moves a routine from its store into on-chip ram
`default_nettype none
module download_engine #(
  parameter int WORDS  = 16,
  parameter int UNIT_W = 10
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              start,
  input  wire logic [1:0]        dest_unit,
  output logic [UNIT_W-1:0]      rom_addr,
  input  wire logic [31:0]       rom_data,
  output logic                   ram_wr_en,
  output logic [UNIT_W+1:0]      ram_wr_addr,
  output logic [31:0]            ram_wr_data,
  output logic                   done
);
  logic              active;
  logic              pend;
  logic              pend_last;
  logic [1:0]        unit;
  logic [UNIT_W-1:0] pend_idx;
  wire               at_last;

  assign at_last = (rom_addr == UNIT_W'(WORDS - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active      <= 1'b0;
      pend        <= 1'b0;
      pend_last   <= 1'b0;
      unit        <= 2'h0;
      pend_idx    <= '0;
      rom_addr    <= '0;
      ram_wr_en   <= 1'b0;
      ram_wr_addr <= '0;
      ram_wr_data <= 32'h0000_0000;
      done        <= 1'b0;
    end else begin
      // store data arrive one cycle after the address, hence the pending stage
      pend      <= active;
      pend_last <= active & at_last;
      pend_idx  <= rom_addr;
      ram_wr_en <= pend;
      done      <= pend & pend_last;
      if (pend) begin
        ram_wr_addr <= {unit, pend_idx};
        ram_wr_data <= rom_data;
      end
      if (start && !active) begin
        active   <= 1'b1;
        unit     <= dest_unit;
        rom_addr <= '0;
      end else if (active) begin
        if (at_last) begin
          active <= 1'b0;
        end else begin
          rom_addr <= rom_addr + UNIT_W'(1);
        end
      end
    end
  end
endmodule : download_engine
`default_nettype wire

// >>> logic/flash_key_and_array_select.sv
// flash key, erase routine select and array select registers with download and protection control
// Behaviour
// - erase select bits 7..1 read zero
// - erase choose bit resets 0, 1 selects
// - erase choose clears after routine copied
// - key resets 00; download needs A5
// - program/erase allowed only with key 5A
// - AA selects boot array, else user
// - array select resets AA in user boot
// - array select written only from ram
// - boot array unprogrammable in user program mode
// - download copies chosen routine to destination
// - download request clears itself, reads zero
`include "flash_key_defs.svh"
`default_nettype none
module flash_key_and_array_select #(
  parameter int ROUTINE_WORDS = `ROUTINE_WORDS,
  parameter int UNIT_WORD_AW  = `UNIT_WORD_AW
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [`FKS_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`FKS_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    user_boot_mode,
  input  wire logic                    boot_mode,
  input  wire logic                    external_programmer_mode,
  input  wire logic                    user_program_mode,
  input  wire logic                    cpu_in_ram,
  input  wire logic                    program_routine_choose,
  input  wire logic [7:0]              download_destination_address,
  input  wire logic                    pe_start,
  input  wire logic                    pe_done,
  output logic                         program_erase_enable,
  output logic                         boot_array_selected,
  output logic                         erase_routine_fetch,
  output logic [UNIT_WORD_AW-1:0]      rom_addr,
  input  wire logic [31:0]             rom_data,
  output logic                         ram_wr_en,
  output logic [UNIT_WORD_AW+1:0]      ram_wr_addr,
  output logic [31:0]                  ram_wr_data,
  output logic                         download_busy
);
  if (ROUTINE_WORDS < 1 || ROUTINE_WORDS > (1 << UNIT_WORD_AW)) begin : bad_routine_words
    $error("ROUTINE_WORDS must be between 1 and one destination unit");
  end

  function automatic logic is_ofs(input logic [`FKS_ADDR_W-1:0] addr,
                                  input logic [`FKS_ADDR_W-1:0] ofs);
    is_ofs = (addr == ofs);
  endfunction : is_ofs

  // bus side
  logic                     wr_stb;
  logic [`FKS_ADDR_W-1:0]   wr_addr;
  logic [31:0]              wr_data;
  logic [`FKS_ADDR_W-1:0]   rd_addr;
  logic [31:0]              rd_data;

  // registers
  logic                     erase_routine_choose;
  logic [7:0]               flash_key;
  logic [7:0]               flash_array_select;
  logic                     pe_refused;
  flash_key_pkg::pe_state_t pe_state;
  flash_key_pkg::pe_state_t next_pe_state;
  flash_key_pkg::dl_state_t dl_state;
  flash_key_pkg::dl_state_t next_dl_state;
  logic                     routine_is_erase;
  logic                     copy_done;

  // write decode
  wire wr_erase_sel = wr_stb & is_ofs(wr_addr, `OFS_ERASE_SEL);
  wire wr_key       = wr_stb & is_ofs(wr_addr, `OFS_KEY);
  wire wr_array_sel = wr_stb & is_ofs(wr_addr, `OFS_ARRAY_SEL);
  wire wr_dl_ctrl   = wr_stb & is_ofs(wr_addr, `OFS_DL_CTRL);
  wire wr_mapped    = is_ofs(wr_addr, `OFS_ERASE_SEL) | is_ofs(wr_addr, `OFS_KEY) |
                      is_ofs(wr_addr, `OFS_ARRAY_SEL) | is_ofs(wr_addr, `OFS_DL_CTRL) |
                      is_ofs(wr_addr, `OFS_STATUS);

  // read decode
  wire rd_erase_sel = is_ofs(rd_addr, `OFS_ERASE_SEL);
  wire rd_key       = is_ofs(rd_addr, `OFS_KEY);
  wire rd_array_sel = is_ofs(rd_addr, `OFS_ARRAY_SEL);
  wire rd_dl_ctrl   = is_ofs(rd_addr, `OFS_DL_CTRL);
  wire rd_status    = is_ofs(rd_addr, `OFS_STATUS);
  wire rd_mapped    = rd_erase_sel | rd_key | rd_array_sel | rd_dl_ctrl | rd_status;

  // download request: key value present at the write decides
  wire dest_in_range = (download_destination_address <= `DEST_UNIT_MAX);
  wire routine_chosen = erase_routine_choose | program_routine_choose;
  wire dl_accept = wr_dl_ctrl & wr_data[`DL_REQ_BIT]
                 & (flash_key == `KEY_DOWNLOAD)
                 & cpu_in_ram & routine_chosen & dest_in_range
                 & (dl_state == flash_key_pkg::DL_IDLE);

  // program/erase permission, sampled at the start pulse
  wire key_allows_pe  = (flash_key == `KEY_PROG_ERASE);
  wire boot_array_ok  = ~boot_array_selected
                      | ((boot_mode | external_programmer_mode) & ~user_program_mode);
  wire pe_allowed     = key_allows_pe & boot_array_ok;

  // status word
  wire [31:0] status_word = {28'h0,
                             pe_refused,
                             boot_array_selected,
                             program_erase_enable,
                             download_busy};

  assign boot_array_selected  = (flash_array_select == `ARRAY_BOOT);
  assign program_erase_enable = (pe_state == flash_key_pkg::PE_RUN);
  assign download_busy        = (dl_state == flash_key_pkg::DL_COPY);
  assign erase_routine_fetch  = routine_is_erase;

  // reserved bits of the erase select read zero; download request reads zero
  assign rd_data = rd_erase_sel ? {31'h0, erase_routine_choose} :
                   rd_key       ? {24'h0, flash_key} :
                   rd_array_sel ? {24'h0, flash_array_select} :
                   rd_dl_ctrl   ? 32'h0000_0000 :
                   rd_status    ? status_word :
                                  32'h0000_0000;

  axi_lite_regs #(
    .AW (`FKS_ADDR_W)
  ) u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_stb  (wr_stb),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_ok   (wr_mapped),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_mapped)
  );

  download_engine #(
    .WORDS  (ROUTINE_WORDS),
    .UNIT_W (UNIT_WORD_AW)
  ) u_copy (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .start       (dl_accept),
    .dest_unit   (download_destination_address[1:0]),
    .rom_addr    (rom_addr),
    .rom_data    (rom_data),
    .ram_wr_en   (ram_wr_en),
    .ram_wr_addr (ram_wr_addr),
    .ram_wr_data (ram_wr_data),
    .done        (copy_done)
  );

  // erase routine choose; a software write in the completion cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_routine_choose <= 1'(`ERASE_SEL_RESET >> `ERASE_CHOOSE_BIT);
    end else if (wr_erase_sel) begin
      erase_routine_choose <= wr_data[`ERASE_CHOOSE_BIT];
    end else if (copy_done && routine_is_erase) begin
      erase_routine_choose <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_key <= `KEY_RESET;
    end else if (wr_key) begin
      flash_key <= wr_data[7:0];
    end
  end

  // user boot mode is sampled while reset is held, so the first cycle already has it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_array_select <= user_boot_mode ? `ARRAY_BOOT : `ARRAY_USER_RESET;
    end else if (wr_array_sel && cpu_in_ram) begin
      flash_array_select <= wr_data[7:0];
    end
  end

  // routine choice is frozen for the whole copy; program wins if both are set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      routine_is_erase <= 1'b0;
    end else if (dl_accept) begin
      routine_is_erase <= erase_routine_choose & ~program_routine_choose;
    end
  end

  always_comb begin
    next_dl_state = dl_state;
    case (dl_state)
      flash_key_pkg::DL_IDLE: begin
        if (dl_accept) begin
          next_dl_state = flash_key_pkg::DL_COPY;
        end
      end
      flash_key_pkg::DL_COPY: begin
        if (copy_done) begin
          next_dl_state = flash_key_pkg::DL_IDLE;
        end
      end
      default: begin
        next_dl_state = flash_key_pkg::DL_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dl_state <= flash_key_pkg::DL_IDLE;
    end else begin
      dl_state <= next_dl_state;
    end
  end

  // a refused operation is held until its done so the array never sees it
  always_comb begin
    next_pe_state = pe_state;
    case (pe_state)
      flash_key_pkg::PE_IDLE: begin
        if (pe_start) begin
          next_pe_state = pe_allowed ? flash_key_pkg::PE_RUN : flash_key_pkg::PE_REFUSED;
        end
      end
      flash_key_pkg::PE_RUN: begin
        if (pe_done) begin
          next_pe_state = flash_key_pkg::PE_IDLE;
        end
      end
      flash_key_pkg::PE_REFUSED: begin
        if (pe_done) begin
          next_pe_state = flash_key_pkg::PE_IDLE;
        end
      end
      default: begin
        next_pe_state = flash_key_pkg::PE_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pe_state   <= flash_key_pkg::PE_IDLE;
      pe_refused <= 1'b0;
    end else begin
      pe_state <= next_pe_state;
      if (pe_state == flash_key_pkg::PE_IDLE && pe_start) begin
        pe_refused <= ~pe_allowed;
      end
    end
  end
endmodule : flash_key_and_array_select
`default_nettype wire

// >>> logic/flash_key_defs.svh
// offsets, field positions, reset values and key codes of the flash key and array select block
`ifndef FLASH_KEY_DEFS_SVH
`define FLASH_KEY_DEFS_SVH

`define FKS_ADDR_W          8
`define OFS_ERASE_SEL       8'h00
`define OFS_KEY             8'h04
`define OFS_ARRAY_SEL       8'h08
`define OFS_DL_CTRL         8'h0C
`define OFS_STATUS          8'h10

`define ERASE_SEL_RESET     8'h00
`define KEY_RESET           8'h00
`define ARRAY_USER_RESET    8'h00
`define ARRAY_BOOT          8'hAA
`define KEY_DOWNLOAD        8'hA5
`define KEY_PROG_ERASE      8'h5A
`define DEST_UNIT_MAX       8'h03

`define ERASE_CHOOSE_BIT    0
`define DL_REQ_BIT          0
`define ST_DL_BUSY_BIT      0
`define ST_PE_ENABLE_BIT    1
`define ST_BOOT_ARRAY_BIT   2
`define ST_PE_REFUSED_BIT   3

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`define ROUTINE_WORDS       16
`define UNIT_WORD_AW        10

`endif

// >>> logic/flash_key_pkg.sv
// state types of the flash key and array select block
`default_nettype none
package flash_key_pkg;
  typedef enum logic [2:0] {
    PE_IDLE    = 3'h1,
    PE_RUN     = 3'h2,
    PE_REFUSED = 3'h4
  } pe_state_t;
  typedef enum logic [1:0] {
    DL_IDLE = 2'h1,
    DL_COPY = 2'h2
  } dl_state_t;
endpackage : flash_key_pkg
`default_nettype wire

// >>> test/flash_key_and_array_select_sva.sv
// concurrent checks on the ports of the flash key and array select block
`default_nettype none
module flash_key_and_array_select_sva #(
  parameter int ROUTINE_WORDS = 16
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        user_boot_mode,
  input wire logic        boot_mode,
  input wire logic        external_programmer_mode,
  input wire logic        user_program_mode,
  input wire logic        pe_start,
  input wire logic        pe_done,
  input wire logic        program_erase_enable,
  input wire logic        boot_array_selected,
  input wire logic        ram_wr_en,
  input wire logic [11:0] ram_wr_addr,
  input wire logic        download_busy
);
  // fixed bound covers the longest routine this code base uses
  localparam int DL_MAX = 40;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  a_strap_reset: assert property ($rose(aresetn) |-> boot_array_selected == user_boot_mode)
    else $error("array select reset value does not follow the boot strap");
  a_pe_cause: assert property ($rose(program_erase_enable) |-> $past(pe_start))
    else $error("program enable rose without a start request");
  a_boot_protect: assert property (pe_start && !program_erase_enable && boot_array_selected
    && user_program_mode && !boot_mode && !external_programmer_mode |=> !program_erase_enable)
    else $error("boot array enabled in user program mode");
  a_pe_release: assert property (program_erase_enable && pe_done |-> ##[1:2] !program_erase_enable)
    else $error("program enable held after done");
  a_copy_busy: assert property (ram_wr_en |-> download_busy)
    else $error("ram write outside a download");
  a_copy_step: assert property (ram_wr_en && $past(ram_wr_en) |-> ram_wr_addr == $past(ram_wr_addr) + 12'h001)
    else $error("ram write address did not step by one");
  a_copy_ends: assert property ($rose(download_busy) |-> ##[1:DL_MAX] !download_busy)
    else $error("download never completed");
endmodule : flash_key_and_array_select_sva

bind flash_key_and_array_select flash_key_and_array_select_sva #(.ROUTINE_WORDS(ROUTINE_WORDS)) chk (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .user_boot_mode, .boot_mode, .external_programmer_mode, .user_program_mode, .pe_start, .pe_done,
  .program_erase_enable, .boot_array_selected, .ram_wr_en, .ram_wr_addr, .download_busy
);
`default_nettype wire

// >>> test/tb_flash_key_and_array_select.sv
// self-checking bench for the flash key and array select block
`include "flash_key_defs.svh"
`default_nettype none
module tb_flash_key_and_array_select;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WORDS = 4;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic ram; logic [7:0] e;} row_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, user_boot_mode, boot_mode;
  logic        external_programmer_mode, user_program_mode, cpu_in_ram, program_routine_choose, pe_start, pe_done;
  logic        program_erase_enable, boot_array_selected, erase_routine_fetch, ram_wr_en, download_busy;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, download_destination_address;
  logic [31:0] s_axi_wdata, s_axi_rdata, rom_data, ram_wr_data, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, bsp;
  logic [9:0]  rom_addr;
  logic [11:0] ram_wr_addr;
  int          n_errors, total_checks, n_words;
  row_t        rows [8];

  flash_key_and_array_select #(.ROUTINE_WORDS(WORDS), .UNIT_WORD_AW(10)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .user_boot_mode, .boot_mode,
    .external_programmer_mode, .user_program_mode, .cpu_in_ram, .program_routine_choose,
    .download_destination_address, .pe_start, .pe_done, .program_erase_enable, .boot_array_selected,
    .erase_routine_fetch, .rom_addr, .rom_data, .ram_wr_en, .ram_wr_addr, .ram_wr_data, .download_busy
  );

  always #2.5 aclk = ~aclk;
  // routine store answers one cycle after the address, word content equals its index
  always @(posedge aclk) rom_data <= {22'h0, rom_addr};

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  always @(posedge aclk) if (ram_wr_en === 1'b1) begin
    n_words <= n_words + 1;
    check("ram data", ram_wr_data, {22'h0, ram_wr_addr[9:0]});
    check("ram unit", {30'h0, ram_wr_addr[11:10]}, 32'h2);
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic sa, sw, sb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    sb = 1'b0;
    while (!sb) begin
      @(negedge aclk);
      sa = s_axi_awvalid && s_axi_awready;
      sw = s_axi_wvalid && s_axi_wready;
      sb = s_axi_bvalid;
      bsp = s_axi_bresp;
      @(posedge aclk);
      if (sa) s_axi_awvalid <= 1'b0;
      if (sw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic sa, sr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    sr = 1'b0;
    while (!sr) begin
      @(negedge aclk);
      sa = s_axi_arvalid && s_axi_arready;
      sr = s_axi_rvalid;
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (sa) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string name);
    rd(a);
    check(name, rdv, exp);
  endtask : rc

  // one-cycle pulse on pe_done when is_done is set, else on pe_start
  task automatic pulse(input logic is_done);
    @(posedge aclk);
    if (is_done) pe_done <= 1'b1;
    else pe_start <= 1'b1;
    @(posedge aclk);
    pe_start <= 1'b0;
    pe_done <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask : pulse

  task automatic do_reset(input logic ub);
    aresetn <= 1'b0;
    user_boot_mode <= ub;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    tally_and_finish;
  end

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {user_boot_mode, boot_mode, external_programmer_mode, user_program_mode, cpu_in_ram} = '0;
    {program_routine_choose, pe_start, pe_done, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {n_errors, total_checks, n_words} = '0;
    download_destination_address = 8'h02;
    s_axi_wstrb = 4'hF;
    rows = '{'{`OFS_ERASE_SEL, 8'h01, 1'b1, 8'h01}, '{`OFS_ERASE_SEL, 8'h00, 1'b1, 8'h00},
             '{`OFS_KEY, 8'h5A, 1'b0, 8'h5A}, '{`OFS_ARRAY_SEL, 8'hAA, 1'b1, 8'hAA},
             '{`OFS_ARRAY_SEL, 8'h55, 1'b0, 8'hAA}, '{`OFS_ARRAY_SEL, 8'h55, 1'b1, 8'h55},
             '{`OFS_DL_CTRL, 8'h00, 1'b1, 8'h00}, '{`OFS_KEY, 8'h00, 1'b1, 8'h00}};
    do_reset(1'b0);
    rc(`OFS_ERASE_SEL, 32'h0, "erase select reset");
    rc(`OFS_KEY, 32'h0, "key reset");
    rc(`OFS_ARRAY_SEL, 32'h0, "array select reset");
    check("boot array reset", {31'h0, boot_array_selected}, 32'h0);
    foreach (rows[i]) begin
      cpu_in_ram <= rows[i].ram;
      wr(rows[i].a, {24'h0, rows[i].d});
      rc(rows[i].a, {24'h0, rows[i].e}, "register readback");
    end
    rd(8'h40);
    check("unmapped resp", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
    check("unmapped data", rdv, 32'h0);
    wr(8'h40, 32'h1);
    check("unmapped write resp", {30'h0, bsp}, {30'h0, `RESP_SLVERR});
    wr(`OFS_ERASE_SEL, 32'h1);
    check("write resp", {30'h0, bsp}, {30'h0, `RESP_OKAY});
    wr(`OFS_DL_CTRL, 32'h1);
    @(negedge aclk);
    check("download without key", {31'h0, download_busy}, 32'h0);
    wr(`OFS_KEY, {24'h0, `KEY_DOWNLOAD});
    wr(`OFS_DL_CTRL, 32'h1);
    @(negedge aclk);
    check("download busy", {31'h0, download_busy}, 32'h1);
    check("erase routine fetch", {31'h0, erase_routine_fetch}, 32'h1);
    while (download_busy === 1'b1) @(negedge aclk);
    check("words copied", n_words, WORDS);
    rc(`OFS_ERASE_SEL, 32'h0, "erase choose after copy");
    rc(`OFS_DL_CTRL, 32'h0, "download request readback");
    wr(`OFS_KEY, {24'h0, `KEY_PROG_ERASE});
    pulse(1'b0);
    check("enable with key", {31'h0, program_erase_enable}, 32'h1);
    pulse(1'b1);
    check("enable after done", {31'h0, program_erase_enable}, 32'h0);
    wr(`OFS_KEY, 32'h0);
    pulse(1'b0);
    check("enable without key", {31'h0, program_erase_enable}, 32'h0);
    // a refused run still ends with done before the next start is looked at
    pulse(1'b1);
    wr(`OFS_ARRAY_SEL, {24'h0, `ARRAY_BOOT});
    wr(`OFS_KEY, {24'h0, `KEY_PROG_ERASE});
    user_program_mode <= 1'b1;
    pulse(1'b0);
    check("boot array in user mode", {31'h0, program_erase_enable}, 32'h0);
    rc(`OFS_STATUS, 32'h0000000C, "status refused");
    pulse(1'b1);
    user_program_mode <= 1'b0;
    boot_mode <= 1'b1;
    pulse(1'b0);
    check("boot array in boot mode", {31'h0, program_erase_enable}, 32'h1);
    pulse(1'b1);
    boot_mode <= 1'b0;
    external_programmer_mode <= 1'b1;
    pulse(1'b0);
    check("boot array in programmer mode", {31'h0, program_erase_enable}, 32'h1);
    pulse(1'b1);
    do_reset(1'b1);
    rc(`OFS_ARRAY_SEL, {24'h0, `ARRAY_BOOT}, "array select boot reset");
    check("boot array after strap", {31'h0, boot_array_selected}, 32'h1);
    tally_and_finish;
  end
endmodule : tb_flash_key_and_array_select
`default_nettype wire
